// >>> hw/acc_pkg.sv
// ************************************************************
// Conversion timing control constants and types
// ************************************************************
package acc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_ACTIVE = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_RES_HI = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SC = 1;
  localparam int CTRL_ATE = 2;
  localparam int CTRL_FLAG = 3;
  localparam int CTRL_PS_LO = 4;
  localparam int CTRL_PS_HI = 6;
  localparam int CTRL_DIFF = 7;
  localparam int CTRL_FREE = 8;

  // Selection register fields
  localparam int SEL_CH_HI = 4;
  localparam int SEL_REF_LO = 6;
  localparam int SEL_REF_HI = 7;

  // Conversion lengths in converter clock cycles
  localparam int CYC_NORM = 13;
  localparam int CYC_FIRST = 25;
  // Timings counted in converter half cycles
  localparam logic [5:0] HALF_NORM = 6'(2 * CYC_NORM);
  localparam logic [5:0] HALF_FIRST = 6'(2 * CYC_FIRST);
  localparam logic [5:0] HALF_AUTO = 6'h1B;
  localparam logic [5:0] SH_NORM = 6'h03;
  localparam logic [5:0] SH_FIRST = 6'h1B;
  localparam logic [5:0] SH_AUTO = 6'h04;
  // Final converter cycle where selection copying resumes
  localparam logic [5:0] HALF_TAIL = 6'h02;

  // Reference sources
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h3;

  typedef struct packed {
    logic [1:0] reference_select;
    logic [4:0] channel_select;
  } acc_sel_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} acc_state_t;

endpackage : acc_pkg

// >>> hw/acc_top.sv
`timescale 1ns/1ps
// Operation
// - Prescaler runs only while converter enabled
// - Start on next converter clock rising edge
// - Normal conversion lasts 13 converter cycles
// - First conversion after enable lasts 25
// - Sample at 1.5 or 13.5 cycles
// - Completion stores result, sets flag, clears start
// - Trigger event resets prescaler
// - Auto: sample at 2, total 13.5
// - Three CPU cycles of trigger synchronisation
// - Differential auto-trigger conversions last 25
// - Free running restarts, start bit stays set
// - Selection follows temp until start, locked
// - Copying resumes in last converter cycle
// - Free-running change applies one conversion later
// - Reference: supply, internal 1.1V, external pin
// - Trigger edge during conversion is ignored
// - Low byte read blocks result until high
module acc_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Converter core
  input wire logic TRIGGER_IN,
  input wire logic [9:0] CORE_RESULT,
  output logic ADC_CLK,
  output logic SAMPLE_HOLD,
  output logic CONV_DONE,
  output logic CONV_BUSY,
  output acc_pkg::acc_sel_t ACTIVE_SEL
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [6:0] ratio_m1(input logic [2:0] sel);
    ratio_m1 = (sel == 3'h0) ? 7'h01 : 7'((8'h01 << sel) - 8'h01);
  endfunction : ratio_m1

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
    is_reg = (addr == ofs);
  endfunction : is_reg

  logic en_ff, sc_ff, ate_ff, flag_ff, diff_ff, free_ff;
  logic [2:0] ps_ff;
  acc_pkg::acc_sel_t temp_ff, active_ff;
  acc_pkg::acc_state_t state_ff;
  logic [6:0] presc_ff;
  logic [5:0] halves_ff, done_ff, sh_ff;
  logic first_ff, res_lock_ff;
  logic [9:0] result_ff;
  logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic pready_ff, pslverr_ff, adc_clk_ff, sh_pulse_ff, done_pulse_ff;
  logic [31:0] prdata_ff;
  logic [11:0] cyc_ff;

  logic acc_wr, acc_rd, rise_evt, half_evt, trig_edge, trig_start, sw_start;
  logic done_evt, locked, restart;
  logic [6:0] rm1;

  assign acc_wr = PSEL & PENABLE & pready_ff & PWRITE;
  assign acc_rd = PSEL & PENABLE & pready_ff & ~PWRITE;
  assign rm1 = ratio_m1(ps_ff);
  assign rise_evt = en_ff & (presc_ff == rm1);
  assign half_evt = rise_evt | (en_ff & (presc_ff == (rm1 >> 1)));
  assign trig_edge = trig_s2_ff & ~trig_s3_ff;
  assign trig_start = trig_edge & en_ff & ate_ff & ~free_ff & (state_ff == acc_pkg::ST_IDLE);
  assign sw_start = acc_wr & is_reg(PADDR, acc_pkg::OFS_CTRL) & PWDATA[acc_pkg::CTRL_SC];
  assign done_evt = (state_ff == acc_pkg::ST_CONV) & half_evt & ((halves_ff + 6'h01) == done_ff);
  assign restart = done_evt & free_ff & ate_ff;
  assign locked = (state_ff == acc_pkg::ST_CONV) & ((halves_ff + acc_pkg::HALF_TAIL) < done_ff);

  // ************************************************************
  // APB slave
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= PSEL & ~PENABLE;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      if (PSEL & ~PENABLE & ~PWRITE) begin
        unique case (PADDR)
          acc_pkg::OFS_CTRL: prdata_ff <= {23'h000000, free_ff, diff_ff, ps_ff, flag_ff,
                                          ate_ff, sc_ff, en_ff};
          acc_pkg::OFS_SEL: prdata_ff <= {24'h000000, temp_ff.reference_select, 1'b0,
                                         temp_ff.channel_select};
          acc_pkg::OFS_ACTIVE: prdata_ff <= {24'h000000, active_ff.reference_select, 1'b0,
                                            active_ff.channel_select};
          acc_pkg::OFS_RES_LO: prdata_ff <= {24'h000000, result_ff[7:0]};
          acc_pkg::OFS_RES_HI: prdata_ff <= {30'h00000000, result_ff[9:8]};
          acc_pkg::OFS_STATUS: prdata_ff <= {27'h0000000, res_lock_ff, first_ff,
                                            locked, state_ff};
          default: pslverr_ff <= 1'b1;
        endcase
      end else if (PSEL & ~PENABLE) begin
        pslverr_ff <= ~(is_reg(PADDR, acc_pkg::OFS_CTRL) | is_reg(PADDR, acc_pkg::OFS_SEL));
      end
    end
  end

  // ************************************************************
  // Control bits
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      en_ff <= 1'b0;
      ate_ff <= 1'b0;
      ps_ff <= 3'h0;
      diff_ff <= 1'b0;
      free_ff <= 1'b0;
    end else if (acc_wr & is_reg(PADDR, acc_pkg::OFS_CTRL)) begin
      en_ff <= PWDATA[acc_pkg::CTRL_EN];
      ate_ff <= PWDATA[acc_pkg::CTRL_ATE];
      ps_ff <= PWDATA[acc_pkg::CTRL_PS_HI:acc_pkg::CTRL_PS_LO];
      diff_ff <= PWDATA[acc_pkg::CTRL_DIFF];
      free_ff <= PWDATA[acc_pkg::CTRL_FREE];
    end
  end

  // Completion flag, write one to clear, set wins
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= done_evt | (flag_ff & ~(acc_wr & is_reg(PADDR, acc_pkg::OFS_CTRL)
                                         & PWDATA[acc_pkg::CTRL_FLAG]));
    end
  end

  // ************************************************************
  // Prescaler and trigger synchroniser
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST | ~en_ff | trig_start) begin
      presc_ff <= 7'h00;
    end else begin
      presc_ff <= (presc_ff == rm1) ? 7'h00 : presc_ff + 7'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      adc_clk_ff <= 1'b0;
    end else begin
      adc_clk_ff <= en_ff & (presc_ff > (rm1 >> 1));
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      trig_s1_ff <= 1'b0;
      trig_s2_ff <= 1'b0;
      trig_s3_ff <= 1'b0;
    end else begin
      trig_s1_ff <= TRIGGER_IN;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST | ~en_ff) begin
      state_ff <= acc_pkg::ST_IDLE;
      sc_ff <= 1'b0;
      halves_ff <= 6'h00;
      done_ff <= acc_pkg::HALF_FIRST;
      sh_ff <= acc_pkg::SH_FIRST;
    end else begin
      unique case (state_ff)
        acc_pkg::ST_IDLE: begin
          if (sw_start) begin
            state_ff <= acc_pkg::ST_WAIT;
            sc_ff <= 1'b1;
          end else if (trig_start) begin
            state_ff <= acc_pkg::ST_CONV;
            sc_ff <= 1'b1;
            halves_ff <= 6'h00;
            done_ff <= (first_ff | diff_ff) ? acc_pkg::HALF_FIRST : acc_pkg::HALF_AUTO;
            sh_ff <= (first_ff | diff_ff) ? acc_pkg::SH_FIRST : acc_pkg::SH_AUTO;
          end
        end
        acc_pkg::ST_WAIT: begin
          if (rise_evt) begin
            state_ff <= acc_pkg::ST_CONV;
            halves_ff <= 6'h00;
            done_ff <= first_ff ? acc_pkg::HALF_FIRST : acc_pkg::HALF_NORM;
            sh_ff <= first_ff ? acc_pkg::SH_FIRST : acc_pkg::SH_NORM;
          end
        end
        acc_pkg::ST_CONV: begin
          if (restart) begin
            halves_ff <= 6'h00;
            done_ff <= acc_pkg::HALF_NORM;
            sh_ff <= acc_pkg::SH_NORM;
          end else if (done_evt) begin
            state_ff <= acc_pkg::ST_IDLE;
            sc_ff <= 1'b0;
          end else if (half_evt) begin
            halves_ff <= halves_ff + 6'h01;
          end
        end
      endcase
    end
  end

  // First conversion after enable
  always_ff @(posedge CLK_SYS) begin
    if (SRST | ~en_ff) begin
      first_ff <= 1'b1;
    end else if (done_evt) begin
      first_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Selection buffering
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      temp_ff <= '0;
    end else if (acc_wr & is_reg(PADDR, acc_pkg::OFS_SEL)) begin
      temp_ff.channel_select <= PWDATA[acc_pkg::SEL_CH_HI:0];
      temp_ff.reference_select <= PWDATA[acc_pkg::SEL_REF_HI:acc_pkg::SEL_REF_LO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      active_ff <= '0;
    end else if (~locked) begin
      active_ff <= temp_ff;
    end
  end

  // ************************************************************
  // Result and read lock
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      res_lock_ff <= 1'b0;
    end else if (acc_rd & is_reg(PADDR, acc_pkg::OFS_RES_LO)) begin
      res_lock_ff <= 1'b1;
    end else if (acc_rd & is_reg(PADDR, acc_pkg::OFS_RES_HI)) begin
      res_lock_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      result_ff <= 10'h000;
    end else if (done_evt & ~res_lock_ff) begin
      result_ff <= CORE_RESULT;
    end
  end

  // ************************************************************
  // Core strobes
  // ************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sh_pulse_ff <= 1'b0;
      done_pulse_ff <= 1'b0;
    end else begin
      sh_pulse_ff <= (state_ff == acc_pkg::ST_CONV) & half_evt & ~done_evt
                     & ((halves_ff + 6'h01) == sh_ff);
      done_pulse_ff <= done_evt;
    end
  end

  // Cycle count of the running conversion, for checking only
  always_ff @(posedge CLK_SYS) begin
    if (SRST | (state_ff != acc_pkg::ST_CONV) | restart) begin
      cyc_ff <= 12'h000;
    end else begin
      cyc_ff <= cyc_ff + 12'h001;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign ADC_CLK = adc_clk_ff;
  assign SAMPLE_HOLD = sh_pulse_ff;
  assign CONV_DONE = done_pulse_ff;
  assign CONV_BUSY = sc_ff;
  assign ACTIVE_SEL = active_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  AST_PRESC_HELD: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !en_ff |=> presc_ff == 7'h00) else $error("prescaler ran while disabled");

  AST_START_EDGE: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (state_ff == acc_pkg::ST_WAIT && rise_evt && en_ff) |=> state_ff == acc_pkg::ST_CONV
    && halves_ff == 6'h00) else $error("start not on converter edge");

  AST_CONV_LEN: assert property (@(posedge CLK_SYS) disable iff (SRST)
    done_evt |-> 13'(cyc_ff) + 13'h0001 == 13'(done_ff) * 13'({6'h00, rm1} + 13'h0001) / 13'h0002)
    else $error("conversion length wrong");

  AST_FIRST_LEN: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (state_ff == acc_pkg::ST_WAIT && rise_evt && en_ff && first_ff)
    |=> done_ff == acc_pkg::HALF_FIRST && sh_ff == acc_pkg::SH_FIRST)
    else $error("first conversion not long");

  AST_SAMPLE_POINT: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(sh_pulse_ff) |-> $past(halves_ff) + 6'h01 == $past(sh_ff)
    && $past(state_ff) == acc_pkg::ST_CONV) else $error("sample at wrong point");

  AST_DONE_FLAG: assert property (@(posedge CLK_SYS) disable iff (SRST)
    done_evt && !restart |=> flag_ff && !sc_ff && done_pulse_ff)
    else $error("completion did not set flag");

  AST_TRIG_RESET: assert property (@(posedge CLK_SYS) disable iff (SRST)
    trig_start |=> presc_ff == 7'h00 && state_ff == acc_pkg::ST_CONV)
    else $error("trigger did not reset prescaler");

  AST_AUTO_TIME: assert property (@(posedge CLK_SYS) disable iff (SRST)
    trig_start && !first_ff && !diff_ff |=> done_ff == acc_pkg::HALF_AUTO
    && sh_ff == acc_pkg::SH_AUTO) else $error("auto timing wrong");

  AST_EDGE_IGNORED: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (trig_edge && state_ff == acc_pkg::ST_CONV && !done_evt && en_ff && !acc_wr)
    |=> state_ff == acc_pkg::ST_CONV && halves_ff >= $past(halves_ff)
    && done_ff == $past(done_ff)) else $error("edge disturbed conversion");

  AST_SEL_LOCK: assert property (@(posedge CLK_SYS) disable iff (SRST)
    locked |=> $stable(active_ff)) else $error("selection changed while locked");

  AST_RES_LOCK: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (res_lock_ff && done_evt) |=> $stable(result_ff) && flag_ff)
    else $error("locked result overwritten");

endmodule : acc_top

// >>> bench/acc_core_model.sv
`timescale 1ns/1ps
// ************************************************************
// Converter core stand-in
// ************************************************************
module acc_core_model (
  // Clock
  input wire logic clk,
  // From control
  input wire logic sample_hold,
  input wire acc_pkg::acc_sel_t active_sel,
  // To control
  output logic [9:0] core_result
);
  logic [4:0] cnt_ff = 5'h00;
  logic [9:0] res_ff = 10'h000;

  // Result carries the sampled channel and a running count
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      cnt_ff <= cnt_ff + 5'h01;
      res_ff <= {active_sel.channel_select, cnt_ff + 5'h01};
    end
  end

  assign core_result = res_ff;
endmodule : acc_core_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic CLK_SYS = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic TRIGGER_IN = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [9:0] CORE_RESULT;
  logic ADC_CLK;
  logic SAMPLE_HOLD;
  logic CONV_DONE;
  logic CONV_BUSY;
  acc_pkg::acc_sel_t ACTIVE_SEL;
  logic [31:0] rq;
  logic re;
  logic ck_q = 1'b0;
  logic [4:0] ch_sh;
  logic [1:0] rf [3] = '{2'h3, 2'h0, 2'h1};
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_r, t_rp, t_sh, t_dn, t0, tt, t1, r;
  int n_dn = 0;
  int n0;

  initial forever #5 CLK_SYS = ~CLK_SYS;

  acc_top uut (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TRIGGER_IN(TRIGGER_IN), .CORE_RESULT(CORE_RESULT),
    .ADC_CLK(ADC_CLK), .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_DONE(CONV_DONE),
    .CONV_BUSY(CONV_BUSY), .ACTIVE_SEL(ACTIVE_SEL));

  acc_core_model core (.clk(CLK_SYS), .sample_hold(SAMPLE_HOLD),
    .active_sel(ACTIVE_SEL), .core_result(CORE_RESULT));

  // ************************************************************
  // Monitor, sampled mid-cycle
  // ************************************************************
  always @(negedge CLK_SYS) begin
    cyc++;
    if (ADC_CLK === 1'b1 && ck_q === 1'b0) begin
      t_rp = t_r;
      t_r = cyc;
    end
    ck_q = ADC_CLK;
    if (SAMPLE_HOLD === 1'b1) begin
      t_sh = cyc;
      ch_sh = ACTIVE_SEL.channel_select;
    end
    if (CONV_DONE === 1'b1) begin
      t_dn = cyc;
      n_dn++;
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic rng(input int d, input int lo, input int hi);
    chk(32'(d >= lo && d <= hi), 32'h1);
  endtask : rng

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      w++;
    end while (PREADY !== 1'b1 && w < 50);
    if (PREADY !== 1'b1) err_total++;
    rq = PRDATA;
    re = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_done(input int lim);
    int w;
    w = 0;
    n0 = n_dn;
    while (n_dn == n0 && w < lim) begin
      @(posedge CLK_SYS);
      w++;
    end
    if (n_dn == n0) err_total++;
  endtask : wait_done

  task automatic trig();
    TRIGGER_IN <= 1'b1;
    t0 = cyc;
    repeat (4) @(posedge CLK_SYS);
    TRIGGER_IN <= 1'b0;
  endtask : trig

  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    #200us;
    err_total++;
    complete_run();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (6) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(posedge CLK_SYS);
    rd(8'h00);
    chk(rq, 32'h0);
    rd(8'h1C);
    chk(32'(re), 32'h1);
    repeat (20) @(posedge CLK_SYS) chk(32'(ADC_CLK), 32'h0);
    for (int s = 0; s < 8; s++) begin
      r = 1 << (s == 0 ? 1 : s);
      wr(8'h00, 32'h1 | (32'(s) << 4));
      repeat (2 * r + 4) @(posedge CLK_SYS);
      chk(32'(t_r - t_rp), 32'(r));
      wr(8'h00, 32'h0);
    end
    // Divide by 4 from here on
    wr(8'h00, 32'h21);
    foreach (rf[i]) begin
      wr(8'h04, (32'(rf[i]) << 6) | 32'h15);
      @(negedge CLK_SYS);
      chk(32'(ACTIVE_SEL), (32'(rf[i]) << 5) | 32'h15);
      @(posedge CLK_SYS);
    end
    rd(8'h08);
    chk(rq, 32'h55);
    wr(8'h00, 32'h23);
    t0 = cyc;
    wait_done(400);
    rng(t_dn - t0, 96, 106);
    chk(32'(t_dn - t_sh), 32'd46);
    rd(8'h00);
    chk({23'h0, rq[8:0]}, 32'h29);
    rd(8'h0C);
    chk(rq, 32'hA1);
    rd(8'h10);
    chk(rq, 32'h2);
    wr(8'h00, 32'h29);
    wr(8'h00, 32'h23);
    t0 = cyc;
    repeat (8) @(posedge CLK_SYS);
    wr(8'h04, 32'h49);
    chk(32'(ACTIVE_SEL), 32'h35);
    wait_done(200);
    rng(t_dn - t0, 48, 58);
    chk(32'(t_dn - t_sh), 32'd46);
    chk(32'(ch_sh), 32'h15);
    chk(32'(ACTIVE_SEL), 32'h29);
    rd(8'h0C);
    chk(rq, 32'hA2);
    wr(8'h00, 32'h2B);
    wait_done(200);
    rd(8'h00);
    chk(32'(rq[3]), 32'h1);
    rd(8'h10);
    chk(rq, 32'h2);
    rd(8'h0C);
    chk(rq, 32'hA2);
    rd(8'h14);
    chk(rq, 32'h10);
    wr(8'h00, 32'h2D);
    trig();
    tt = t0;
    repeat (16) @(posedge CLK_SYS);
    trig();
    wait_done(200);
    rng(t_dn - tt, 56, 62);
    chk(32'(t_dn - t_sh), 32'd46);
    repeat (80) @(posedge CLK_SYS);
    chk(32'(n_dn - n0), 32'h1);
    wr(8'h00, 32'hAD);
    trig();
    wait_done(300);
    rng(t_dn - t0, 102, 110);
    wr(8'h00, 32'h12F);
    wait_done(300);
    wr(8'h04, 32'hC3);
    t1 = t_dn;
    wait_done(200);
    chk(32'(ch_sh), 32'h9);
    chk(32'(CONV_BUSY), 32'h1);
    rng(t_dn - t1, 52, 56);
    wait_done(200);
    chk(32'(ch_sh), 32'h3);
    wait_done(200);
    chk(32'(ACTIVE_SEL), 32'h63);
    wr(8'h00, 32'h0);
    complete_run();
  end
endmodule : tb_top
